/* File: tce_params.svh */
// Constants for the sensor configuration and alarm control block
`ifndef TCE_PARAMS_SVH
`define TCE_PARAMS_SVH
`define TCE_REG_CONFIG 8'h01
`define TCE_REG_UPPER 8'h02
`define TCE_REG_LOWER 8'h03
`define TCE_REG_CRIT 8'h04
`define TCE_BIT_HYST_HI 10
`define TCE_BIT_HYST_LO 9
`define TCE_BIT_SHUTDOWN 8
`define TCE_BIT_CRIT_LOCK 7
`define TCE_BIT_WIN_LOCK 6
`define TCE_BIT_ALARM_CLEAR 5
`define TCE_BIT_ALARM_STATUS 4
`define TCE_BIT_ALARM_OE 3
`define TCE_BIT_CRIT_ONLY 2
`define TCE_BIT_POLARITY 1
`define TCE_BIT_MODE 0
`define TCE_CONFIG_RESET 16'h0000
`define TCE_HYST_0P0 13'h0000
`define TCE_HYST_1P5 13'h000C
`define TCE_HYST_3P0 13'h0018
`define TCE_HYST_6P0 13'h0030
`define TCE_TEMP_HIGH_FLAG_BIT 14
`endif

/* File: tce_pkg.sv */
// Types shared by the sensor configuration and alarm control block
package tce_pkg;
	typedef enum logic [1:0] {
		TCE_HYST_NONE,
		TCE_HYST_1P5_C,
		TCE_HYST_3P0_C,
		TCE_HYST_6P0_C
	} tce_hyst_t;
	typedef logic signed [12:0] tce_temp_t;
endpackage

/* File: tce_trip.sv */
// One limit comparator with falling-temperature hysteresis
`timescale 1ns/10ps
module tce_trip
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic sample,
	input wire tce_pkg::tce_temp_t temp,
	input wire tce_pkg::tce_temp_t limit,
	input wire tce_pkg::tce_temp_t margin,
	input wire logic trip_below,
	output logic tripped
);
	import tce_pkg::*;
	logic tripped_q;
	logic signed [13:0] release_pt;
	// Release point sits margin below the limit; wide to avoid wrap
	assign release_pt = 14'(limit) - 14'(margin);
	// ==========================================================
	// Trip state
	// Sets above the limit, releases only below limit minus margin; with trip_below, sets below limit minus margin, releases at or above limit
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			tripped_q <= 1'b0;
		else if (!enable)
			tripped_q <= 1'b0;
		else if (sample)
		begin
			if (trip_below)
				tripped_q <= (14'(temp) < release_pt) ? 1'b1 : (14'(temp) >= 14'(limit)) ? 1'b0 : tripped_q;
			else if (temp > limit)
				tripped_q <= 1'b1;
			else if (14'(temp) < release_pt)
				tripped_q <= 1'b0;
		end
	end
	assign tripped = tripped_q;
endmodule

/* File: tce_config.sv */
// Configuration register and alarm pin control of the temperature sensor
`timescale 1ns/10ps
`include "tce_params.svh"
module tce_config
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	output logic [15:0] config_rdata,
	input wire logic conv_done,
	input wire tce_pkg::tce_temp_t temp_in,
	input wire tce_pkg::tce_temp_t upper_limit,
	input wire tce_pkg::tce_temp_t lower_limit,
	input wire tce_pkg::tce_temp_t crit_limit,
	output logic conv_enable,
	output logic temp_update_en,
	output logic upper_limit_wr_en,
	output logic lower_limit_wr_en,
	output logic crit_limit_wr_en,
	output logic temp_above_upper,
	output logic bus_active,
	output logic alarm_o,
	output logic alarm_oe
);
	import tce_pkg::*;

	// ==========================================================
	// Configuration fields
	tce_hyst_t hyst_q;
	logic shutdown_q;
	logic crit_lock_q;
	logic win_lock_q;
	logic alarm_oe_q;
	logic crit_only_q;
	logic polarity_q;
	logic mode_q;
	logic any_lock;
	logic cfg_wr;
	logic clear_req;
	assign any_lock = crit_lock_q | win_lock_q;
	assign cfg_wr = reg_wr && (reg_addr == `TCE_REG_CONFIG);

	// Hysteresis field, frozen by either lock
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			hyst_q <= TCE_HYST_NONE;
		else if (cfg_wr && !any_lock)
			hyst_q <= tce_hyst_t'(reg_wdata[`TCE_BIT_HYST_HI:`TCE_BIT_HYST_LO]);
	end

	// Shutdown: entry blocked by locks, exit always allowed
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			shutdown_q <= 1'b0;
		else if (cfg_wr)
		begin
			if (!reg_wdata[`TCE_BIT_SHUTDOWN])
				shutdown_q <= 1'b0;
			else if (!any_lock)
				shutdown_q <= 1'b1;
		end
	end

	// Locks only ever set from the bus; only power-on reset clears them
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			crit_lock_q <= 1'b0;
			win_lock_q <= 1'b0;
		end
		else if (cfg_wr)
		begin
			crit_lock_q <= crit_lock_q | reg_wdata[`TCE_BIT_CRIT_LOCK];
			win_lock_q <= win_lock_q | reg_wdata[`TCE_BIT_WIN_LOCK];
		end
	end

	// Pin controls frozen by either lock
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alarm_oe_q <= 1'b0;
			polarity_q <= 1'b0;
			mode_q <= 1'b0;
		end
		else if (cfg_wr && !any_lock)
		begin
			alarm_oe_q <= reg_wdata[`TCE_BIT_ALARM_OE];
			polarity_q <= reg_wdata[`TCE_BIT_POLARITY];
			mode_q <= reg_wdata[`TCE_BIT_MODE];
		end
	end

	// Critical-only filter: the window lock alone freezes it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			crit_only_q <= 1'b0;
		else if (cfg_wr && !win_lock_q)
			crit_only_q <= reg_wdata[`TCE_BIT_CRIT_ONLY];
	end

	// Clear is a strobe only, meaningful in interrupt mode
	assign clear_req = cfg_wr && reg_wdata[`TCE_BIT_ALARM_CLEAR] && mode_q;

	// ==========================================================
	// Conversion control
	// Sensor stops in shutdown; the bus side is never gated here
	assign conv_enable = !shutdown_q;
	assign temp_update_en = !shutdown_q;
	assign bus_active = 1'b1;

	// Limit register write gates
	assign upper_limit_wr_en = !win_lock_q;
	assign lower_limit_wr_en = !win_lock_q;
	assign crit_limit_wr_en = !crit_lock_q;

	// ==========================================================
	// Trip comparators
	tce_temp_t margin;
	logic sample;
	logic trip_upper;
	logic trip_lower;
	logic trip_crit;
	always_comb
	begin
		unique case (hyst_q)
			TCE_HYST_NONE: margin = `TCE_HYST_0P0;
			TCE_HYST_1P5_C: margin = `TCE_HYST_1P5;
			TCE_HYST_3P0_C: margin = `TCE_HYST_3P0;
			TCE_HYST_6P0_C: margin = `TCE_HYST_6P0;
		endcase
	end
	// Comparators only look at fresh samples while converting
	assign sample = conv_done && !shutdown_q;

	tce_trip u_upper (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(1'b1),
		.sample(sample),
		.temp(temp_in),
		.limit(upper_limit),
		.margin(margin),
		.trip_below(1'b0),
		.tripped(trip_upper)
	);
	tce_trip u_crit (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(1'b1),
		.sample(sample),
		.temp(temp_in),
		.limit(crit_limit),
		.margin(margin),
		.trip_below(1'b0),
		.tripped(trip_crit)
	);
	// Lower limit trips on falling temperature, releases at or above it
	tce_trip u_lower (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(1'b1),
		.sample(sample),
		.temp(temp_in),
		.limit(lower_limit),
		.margin(margin),
		.trip_below(1'b1),
		.tripped(trip_lower)
	);
	assign temp_above_upper = trip_upper;

	// ==========================================================
	// Alarm condition and pin state
	logic condition;
	logic fresh_q;
	logic pin_drive;
	logic cond_prev_q;
	logic latched_q;
	logic released_q;
	logic active;
	assign condition = crit_only_q ? trip_crit : (trip_upper | trip_crit | trip_lower);

	// Trips settle one edge after a sample; judging the latch on the sample
	// edge itself would act on the previous conversion's result
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			fresh_q <= 1'b0;
		else
			fresh_q <= sample;
	end

	// Edge memory for interrupt mode, updated only once trips are settled
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cond_prev_q <= 1'b0;
		else if (fresh_q)
			cond_prev_q <= condition;
	end

	// Interrupt latch: a new event in the clear cycle wins
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			latched_q <= 1'b0;
		else if (!alarm_oe_q || !mode_q)
			latched_q <= 1'b0;
		else if (fresh_q && condition && !cond_prev_q)
			latched_q <= 1'b1;
		else if (clear_req)
			latched_q <= 1'b0;
	end

	// Pin stays released from shutdown until the next sample lands
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			released_q <= 1'b0;
		else if (shutdown_q)
			released_q <= 1'b1;
		else if (conv_done)
			released_q <= 1'b0;
	end

	// Pending interrupt may reassert at once after shutdown exit
	always_comb
	begin
		if (shutdown_q || !alarm_oe_q)
			active = 1'b0;
		else if (mode_q)
			active = latched_q;
		else
			active = condition && !released_q;
	end

	// Pin is released in shutdown and after it until a fresh sample; only a
	// pending interrupt may take it back early, so no stale level is driven
	assign pin_drive = alarm_oe_q && !shutdown_q && (!released_q || (mode_q && latched_q));

	// Driven level with selectable active level
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			alarm_o <= 1'b1;
		else
			alarm_o <= active ~^ polarity_q;
	end

	// Output enable, registered so it moves together with the level
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			alarm_oe <= 1'b0;
		else
			alarm_oe <= pin_drive;
	end

	// ==========================================================
	// Readback: reserved and clear bits read zero
	always_comb
	begin
		config_rdata = `TCE_CONFIG_RESET;
		config_rdata[`TCE_BIT_HYST_HI:`TCE_BIT_HYST_LO] = hyst_q;
		config_rdata[`TCE_BIT_SHUTDOWN] = shutdown_q;
		config_rdata[`TCE_BIT_CRIT_LOCK] = crit_lock_q;
		config_rdata[`TCE_BIT_WIN_LOCK] = win_lock_q;
		config_rdata[`TCE_BIT_ALARM_CLEAR] = 1'b0;
		config_rdata[`TCE_BIT_ALARM_STATUS] = active;
		config_rdata[`TCE_BIT_ALARM_OE] = alarm_oe_q;
		config_rdata[`TCE_BIT_CRIT_ONLY] = crit_only_q;
		config_rdata[`TCE_BIT_POLARITY] = polarity_q;
		config_rdata[`TCE_BIT_MODE] = mode_q;
	end
endmodule

/* File: tce_config_asserts.sv */
// Checker for the configuration register and alarm pin block
`timescale 1ns/10ps
module tce_config_chk
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [15:0] config_rdata,
	input wire logic conv_enable,
	input wire logic temp_update_en,
	input wire logic upper_limit_wr_en,
	input wire logic crit_limit_wr_en,
	input wire logic bus_active,
	input wire logic alarm_oe
);
	// ========================================
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	chk_conv_run: assert property (conv_enable == !config_rdata[8] && temp_update_en == conv_enable)
		else $error("conversion enable wrong");
	chk_shut_release: assert property (config_rdata[8] && $past(config_rdata[8]) |-> !alarm_oe)
		else $error("pin driven in shutdown");
	chk_win_lock: assert property (upper_limit_wr_en == !config_rdata[6])
		else $error("window lock gate wrong");
	chk_crit_lock: assert property (crit_limit_wr_en == !config_rdata[7])
		else $error("critical lock gate wrong");
	chk_lock_sticky: assert property ($past(config_rdata[7]) |-> config_rdata[7])
		else $error("critical lock cleared");
	chk_win_sticky: assert property ($past(config_rdata[6]) |-> config_rdata[6])
		else $error("window lock cleared");
	chk_shut_locked: assert property (|config_rdata[7:6] && !config_rdata[8] |=> !config_rdata[8])
		else $error("shutdown set while locked");
	chk_clear_zero: assert property (config_rdata[5] == 1'b0)
		else $error("clear bit reads one");
	chk_locked_hold: assert property (|config_rdata[7:6] |=>
		$stable({config_rdata[10:9], config_rdata[3], config_rdata[1:0]}))
		else $error("locked field changed");
	chk_oe_off: assert property (!config_rdata[3] |-> !config_rdata[4])
		else $error("status set while output off");
	chk_bus_alive: assert property (bus_active)
		else $error("bus gated");
	cov_shut: cover property ($rose(config_rdata[8]));
	cov_lock: cover property ($rose(config_rdata[6]));
	cov_pin: cover property ($rose(alarm_oe));
endmodule
bind tce_config tce_config_chk tce_config_chk_inst (.mclk, .arst_n, .config_rdata, .conv_enable, .temp_update_en,
	.upper_limit_wr_en, .crit_limit_wr_en, .bus_active, .alarm_oe);

/* File: tce_host_model.sv */
// Serial host side: turns a request into one config write strobe
`timescale 1ns/10ps
module tce_host_model
(
	input wire logic mclk,
	input wire logic go,
	input wire logic [15:0] word,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr
);
	// ========================================
	// Idle bus shows inverted data so stale values never pass
	always @(negedge mclk)
	begin
		reg_wr <= go;
		reg_addr <= go ? 8'h01 : 8'hFE;
		reg_wdata <= go ? word : ~reg_wdata;
	end
	initial
	begin
		reg_wr = 1'b0;
		reg_addr = 8'hFE;
		reg_wdata = 16'h0000;
	end
endmodule

/* File: tb_top.sv */
// Testbench for the configuration register and alarm pin block
`timescale 1ns/10ps
module tb_top;
	import tce_pkg::*;
	logic mclk = 0, arst_n = 0, go = 0, conv_done = 0, wr, ce, tu, uw, lw, cw, tau, ba, ao, aoe;
	logic [15:0] word = 16'h0000, rd, wdata;
	logic [7:0] addr;
	tce_temp_t temp = 13'h0000, h;
	int miscompares = 0, n_compared = 0, r;
	// ========================================
	// Clock and instances
	always #50 mclk = ~mclk;
	tce_host_model tce_host_model_inst (.mclk(mclk), .go(go), .word(word), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr));
	tce_config tce_config_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.config_rdata(rd), .conv_done(conv_done), .temp_in(temp), .upper_limit(13'h0280),
		.lower_limit(13'h1FB0), .crit_limit(13'h0320), .conv_enable(ce), .temp_update_en(tu),
		.upper_limit_wr_en(uw), .lower_limit_wr_en(lw), .crit_limit_wr_en(cw), .temp_above_upper(tau),
		.bus_active(ba), .alarm_o(ao), .alarm_oe(aoe));
	// ========================================
	// Tasks, all but the first reset at time 0 entered at a falling edge
	task chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr_cfg(logic [15:0] w);
		word <= w;
		go <= 1'b1;
		@(negedge mclk) go <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task sample(tce_temp_t t);
		temp <= t;
		conv_done <= 1'b1;
		@(negedge mclk) conv_done <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task rst;
		arst_n = 1'b0;
		repeat (12) @(negedge mclk);
		arst_n = 1'b1;
		@(negedge mclk);
	endtask
	task test_done;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Margin in LSB for a code: 0, 12, 24, 48
	function automatic tce_temp_t hlsb(int c);
		return 13'(12 * ((1 << c) >> 1));
	endfunction
	// ========================================
	// Main sequence
	initial
	begin
		r = $urandom(32'h4521a4a1);
		rst;
		chk("reset cfg", 16'h0000, rd);
		wr_cfg(16'h0009);
		sample(13'h02BC);
		chk("int pin", 2'b10, {aoe, ao});
		chk("above upper", 1, tau);
		sample(13'h012C);
		chk("int held", 1, rd[4]);
		wr_cfg(16'h0029);
		chk("int cleared", 0, rd[4]);
		$display("interrupt test done");
		wr_cfg(16'h000E);
		sample(13'h02BC);
		chk("crit only", 0, rd[4]);
		// Lower limit alone raises the pin once the filter is dropped
		sample(13'h1F00);
		wr_cfg(16'h000A);
		chk("below lower", 2'b11, {aoe, ao});
		wr_cfg(16'h002A);
		chk("clear ignored", 1, rd[4]);
		$display("comparator test done");
		for (int c = 0; c < 4; c++)
		begin
			h = hlsb(c);
			wr_cfg({5'h00, 2'(c), 9'h00E});
			sample(13'h0321 + 13'($urandom % 40));
			chk("cmp pin", 2'b11, {aoe, ao});
			sample(13'h0320 - h);
			chk("hyst held", 1, rd[4]);
			sample(13'h031F - h);
			chk("hyst release", 0, rd[4]);
		end
		$display("hysteresis test done");
		wr_cfg(16'h070E);
		sample(13'h0384);
		chk("shutdown", 3'b000, {ce, tu, aoe});
		wr_cfg(16'h060E);
		chk("wake", 3'b110, {ce, tu, aoe});
		sample(13'h0384);
		chk("wake alarm", 1, rd[4]);
		chk("wake pin", 2'b11, {aoe, ao});
		$display("shutdown test done");
		wr_cfg(16'h06CE);
		wr_cfg(16'h0101);
		chk("locked cfg", 16'h06DE, rd);
		chk("limit gates", 3'b000, {uw, lw, cw});
		rst;
		chk("por unlock", 19'h70000, {uw, lw, cw, rd});
		$display("lock test done");
		test_done;
	end
	// Watchdog far beyond the 150 or so cycles needed
	initial
	begin
		#2000000;
		miscompares++;
		test_done;
	end
endmodule
